// file: verilog/fsp_pkg.sv
// Purpose : Shared constants and types for the flash status and protection register bank.
// Assumes : Status bits S0..S23 are carried as one 24-bit packed word.
// Notes   : The struct order fixes every field position, from S23 down to S0.
package fsp_pkg;

  // ----------------------------------------------------------------
  // Instruction opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] FSP_OP_WREN      = 8'h06;
  localparam logic [7:0] FSP_OP_WRDI      = 8'h04;
  localparam logic [7:0] FSP_OP_WSR       = 8'h01;
  localparam logic [7:0] FSP_OP_PP        = 8'h02;
  localparam logic [7:0] FSP_OP_QPP       = 8'h32;
  localparam logic [7:0] FSP_OP_SE        = 8'h20;
  localparam logic [7:0] FSP_OP_BE32      = 8'h52;
  localparam logic [7:0] FSP_OP_BE64      = 8'hd8;
  localparam logic [7:0] FSP_OP_CE        = 8'hc7;
  localparam logic [7:0] FSP_OP_SECR_ER   = 8'h44;
  localparam logic [7:0] FSP_OP_SECR_PG   = 8'h42;
  localparam logic [7:0] FSP_OP_SUSPEND   = 8'h75;
  localparam logic [7:0] FSP_OP_RESUME    = 8'h7a;
  localparam logic [7:0] FSP_OP_QPI_ENTER = 8'h38;
  localparam logic [7:0] FSP_OP_QPI_EXIT  = 8'hff;

  // ----------------------------------------------------------------
  // Lock modes, drive codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] FSP_LOCK_SOFT    = 2'h0;
  localparam logic [1:0] FSP_LOCK_PIN     = 2'h1;
  localparam logic [1:0] FSP_LOCK_PWR     = 2'h2;
  localparam logic [1:0] FSP_DRV_DEFAULT  = 2'h3;
  localparam logic [2:0] FSP_BP_DEFAULT   = 3'h0;
  localparam logic [2:0] FSP_LB_DEFAULT   = 3'h0;
  localparam int         FSP_CLK_MHZ      = 40;
  localparam int         FSP_TW_NS        = 1000;
  localparam int         FSP_TW_CYCLES    = (FSP_TW_NS * FSP_CLK_MHZ) / 1000;
  localparam logic [7:0] FSP_TW_CNT       = 8'(FSP_TW_CYCLES);

  // Status word, S23 first.
  typedef struct packed {
    logic       pin_function_sel;
    logic [1:0] output_strength_sel;
    logic [4:0] rsv_s20_s16;
    logic       paused_op_flag;
    logic       protect_invert;
    logic [2:0] otp_region_locks;
    logic       rsv_s10;
    logic       quad_io_enable;
    logic [1:0] sr_lock_mode;
    logic       small_unit_select;
    logic       top_bottom_select;
    logic [2:0] block_protect_level;
    logic       write_enable_latch;
    logic       busy;
  } fsp_status_t;

  // One instruction from the serial front end.
  typedef struct packed {
    logic [7:0]  op;
    fsp_status_t data;
  } fsp_cmd_t;

endpackage : fsp_pkg

// file: verilog/fsp_status_regs.sv
// Purpose : Status and configuration register bank of a serial flash device.
// Assumes : A serial front end on link_clk delivers decoded instructions and reads
//           back the status word; the array engine reports completion on op_done.
// Notes   : rst is a power cycle; nv_rst restores factory values of non-volatile bits.
module fsp_status_regs
  import fsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        nv_rst,
  input  wire logic        ce,
  input  wire logic        write_guard_pin,
  input  wire logic        op_done,
  input  wire logic        link_clk,
  input  wire logic        lk_cmd_valid,
  input  wire fsp_cmd_t    lk_cmd,
  output logic             lk_cmd_ready,
  output fsp_status_t      lk_status,
  output fsp_status_t      status,
  output logic             quad_cmd_mode,
  output logic             guard_pin_active,
  output logic             pause_pin_active,
  output logic             reset_pin_active,
  output logic [6:0]       drive_pct,
  output logic             wsr_refused
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] drv_pct(input logic [1:0] code);
    case (code)
      2'h0:    drv_pct = 7'h64;
      2'h1:    drv_pct = 7'h4b;
      2'h2:    drv_pct = 7'h32;
      default: drv_pct = 7'h19;
    endcase
  endfunction : drv_pct

  function automatic logic is_array_op(input logic [7:0] op);
    is_array_op = (op == FSP_OP_PP) || (op == FSP_OP_QPP) || (op == FSP_OP_SE) ||
                  (op == FSP_OP_BE32) || (op == FSP_OP_BE64) || (op == FSP_OP_CE) ||
                  (op == FSP_OP_SECR_ER) || (op == FSP_OP_SECR_PG);
  endfunction : is_array_op

  // ----------------------------------------------------------------
  // Link domain: command launch and status capture
  // ----------------------------------------------------------------
  fsp_cmd_t  lk_cmd_hold_reg;
  logic      lk_req_reg;
  logic      lk_ack_s1_reg;
  logic      lk_ack_s2_reg;
  logic      lk_st_req_s1_reg;
  logic      lk_st_req_s2_reg;
  logic      lk_st_ack_reg;
  fsp_status_t st_hold_reg;
  logic      st_req_reg;
  logic      cmd_ack_reg;

  // Command is held stable until the core hands back the toggle.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_cmd_hold_reg <= '0;
      lk_req_reg      <= 1'b0;
    end else if (lk_cmd_valid && (lk_req_reg == lk_ack_s2_reg)) begin
      lk_cmd_hold_reg <= lk_cmd;
      lk_req_reg      <= ~lk_req_reg;
    end
  end

  // Two-flop synchronisers for the core's acknowledge and status request.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_ack_s1_reg    <= 1'b0;
      lk_ack_s2_reg    <= 1'b0;
      lk_st_req_s1_reg <= 1'b0;
      lk_st_req_s2_reg <= 1'b0;
    end else begin
      lk_ack_s1_reg    <= cmd_ack_reg;
      lk_ack_s2_reg    <= lk_ack_s1_reg;
      lk_st_req_s1_reg <= st_req_reg;
      lk_st_req_s2_reg <= lk_st_req_s1_reg;
    end
  end

  // Status word is taken only while the core holds it stable.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_status     <= '0;
      lk_st_ack_reg <= 1'b0;
      lk_cmd_ready  <= 1'b0;
    end else begin
      lk_cmd_ready <= (lk_req_reg == lk_ack_s2_reg) && !lk_cmd_valid;
      if (lk_st_req_s2_reg != lk_st_ack_reg) begin
        lk_status     <= st_hold_reg;
        lk_st_ack_reg <= lk_st_req_s2_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: synchronisers
  // ----------------------------------------------------------------
  logic cmd_s1_reg;
  logic cmd_s2_reg;
  logic st_ack_s1_reg;
  logic st_ack_s2_reg;
  logic guard_s1_reg;
  logic guard_s2_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_s1_reg    <= 1'b0;
      cmd_s2_reg    <= 1'b0;
      st_ack_s1_reg <= 1'b0;
      st_ack_s2_reg <= 1'b0;
      guard_s1_reg  <= 1'b0;
      guard_s2_reg  <= 1'b0;
    end else if (ce) begin
      cmd_s1_reg    <= lk_req_reg;
      cmd_s2_reg    <= cmd_s1_reg;
      st_ack_s1_reg <= lk_st_ack_reg;
      st_ack_s2_reg <= st_ack_s1_reg;
      guard_s1_reg  <= write_guard_pin;
      guard_s2_reg  <= guard_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  fsp_cmd_t    cmd;
  fsp_status_t wd;
  logic        cmd_new;
  logic        busy_reg;
  logic        wel_reg;
  logic        sus_reg;
  logic        wsr_busy_reg;
  logic [7:0]  tw_cnt_reg;
  logic        pwrup_reg;
  logic [2:0]  bp_reg;
  logic        tb_reg;
  logic        sec_reg;
  logic        cmp_reg;
  logic [1:0]  srp_reg;
  logic [2:0]  lb_reg;
  logic        qe_reg;
  logic [1:0]  drv_reg;
  logic        pinfn_reg;
  logic        wsr_ok;
  logic        wsr_cmd;
  logic        guard_high;

  // The held command is stable while the request toggle differs from ack.
  assign cmd     = lk_cmd_hold_reg;
  assign wd      = cmd.data;
  assign cmd_new = ce && (cmd_s2_reg != cmd_ack_reg);
  assign wsr_cmd = cmd_new && !busy_reg && (cmd.op == FSP_OP_WSR);
  // With quad enabled the guard pin is a data line and has no say.
  assign guard_high = guard_s2_reg || qe_reg;

  always_comb begin
    case (srp_reg)
      FSP_LOCK_SOFT: wsr_ok = wel_reg;
      FSP_LOCK_PIN:  wsr_ok = wel_reg && guard_high;
      default:       wsr_ok = 1'b0;
    endcase
  end

  // Acknowledge closes the command handshake one cycle after decode.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_ack_reg <= 1'b0;
    end else if (cmd_new) begin
      cmd_ack_reg <= cmd_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Volatile status: latch, busy, suspend, quad mode
  // ----------------------------------------------------------------
  // latch set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wel_reg <= 1'b0;
    end else if (cmd_new && !busy_reg) begin
      if (cmd.op == FSP_OP_WREN) begin
        wel_reg <= 1'b1;
      end else if ((cmd.op == FSP_OP_WRDI) || is_array_op(cmd.op) ||
                   ((cmd.op == FSP_OP_WSR) && wsr_ok)) begin
        wel_reg <= 1'b0;
      end
    end
  end

  // busy tracking
  // Array work ends on op_done; a status write ends on its own timer.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg     <= 1'b0;
      wsr_busy_reg <= 1'b0;
      tw_cnt_reg   <= 8'h00;
    end else if (ce) begin
      if (wsr_busy_reg) begin
        if (tw_cnt_reg <= 8'h01) begin
          busy_reg     <= 1'b0;
          wsr_busy_reg <= 1'b0;
        end
        tw_cnt_reg <= tw_cnt_reg - 8'h01;
      end else if (busy_reg && op_done) begin
        busy_reg <= 1'b0;
      end else if (cmd_new && busy_reg && (cmd.op == FSP_OP_SUSPEND)) begin
        busy_reg <= 1'b0;
      end else if (cmd_new && !busy_reg && sus_reg && (cmd.op == FSP_OP_RESUME)) begin
        busy_reg <= 1'b1;
      end else if (cmd_new && !busy_reg && wel_reg && is_array_op(cmd.op)) begin
        busy_reg <= 1'b1;
      end else if (wsr_cmd && wsr_ok) begin
        busy_reg     <= 1'b1;
        wsr_busy_reg <= 1'b1;
        tw_cnt_reg   <= FSP_TW_CNT;
      end
    end
  end

  // suspend flag
  // A status write in progress cannot be suspended, only array work.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sus_reg <= 1'b0;
    end else if (cmd_new) begin
      if ((cmd.op == FSP_OP_SUSPEND) && busy_reg && !wsr_busy_reg) begin
        sus_reg <= 1'b1;
      end else if ((cmd.op == FSP_OP_RESUME) && !busy_reg) begin
        sus_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quad_cmd_mode <= 1'b0;
    end else if (cmd_new && !busy_reg) begin
      if ((cmd.op == FSP_OP_QPI_ENTER) && qe_reg) begin
        quad_cmd_mode <= 1'b1;
      end else if (cmd.op == FSP_OP_QPI_EXIT) begin
        quad_cmd_mode <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Non-volatile fields
  // ----------------------------------------------------------------
  // Power-up marker lets the lock-down mode fall back after a power cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwrup_reg <= 1'b1;
    end else if (ce) begin
      pwrup_reg <= 1'b0;
    end
  end

  // protection, drive and pin function fields
  // These bits survive rst; only nv_rst restores factory values.
  always_ff @(posedge clk or posedge nv_rst) begin
    if (nv_rst) begin
      bp_reg    <= FSP_BP_DEFAULT;
      tb_reg    <= 1'b0;
      sec_reg   <= 1'b0;
      cmp_reg   <= 1'b0;
      drv_reg   <= FSP_DRV_DEFAULT;
      pinfn_reg <= 1'b0;
    end else if (wsr_cmd && wsr_ok) begin
      bp_reg    <= wd.block_protect_level;
      tb_reg    <= wd.top_bottom_select;
      sec_reg   <= wd.small_unit_select;
      cmp_reg   <= wd.protect_invert;
      drv_reg   <= wd.output_strength_sel;
      pinfn_reg <= wd.pin_function_sel;
    end
  end

  always_ff @(posedge clk or posedge nv_rst) begin
    if (nv_rst) begin
      srp_reg <= FSP_LOCK_SOFT;
      lb_reg  <= FSP_LB_DEFAULT;
      qe_reg  <= 1'b0;
    end else if (ce && pwrup_reg) begin
      if (srp_reg == FSP_LOCK_PWR) begin
        srp_reg <= FSP_LOCK_SOFT;
      end
    end else if (wsr_cmd && wsr_ok) begin
      srp_reg <= wd.sr_lock_mode;
      lb_reg  <= lb_reg | wd.otp_region_locks;
      qe_reg  <= wd.quad_io_enable | quad_cmd_mode;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // pin roles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      guard_pin_active <= 1'b0;
      pause_pin_active <= 1'b0;
      reset_pin_active <= 1'b0;
      drive_pct        <= 7'h00;
      wsr_refused      <= 1'b0;
    end else if (ce) begin
      guard_pin_active <= !qe_reg;
      pause_pin_active <= !qe_reg && !pinfn_reg;
      reset_pin_active <= !qe_reg && pinfn_reg;
      drive_pct        <= drv_pct(drv_reg);
      wsr_refused      <= wsr_cmd && !wsr_ok;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else if (ce) begin
      status                     <= '0;
      status.busy                <= busy_reg;
      status.write_enable_latch  <= wel_reg;
      status.block_protect_level <= bp_reg;
      status.top_bottom_select   <= tb_reg;
      status.small_unit_select   <= sec_reg;
      status.sr_lock_mode        <= srp_reg;
      status.quad_io_enable      <= qe_reg;
      status.otp_region_locks    <= lb_reg;
      status.protect_invert      <= cmp_reg;
      status.paused_op_flag      <= sus_reg;
      status.output_strength_sel <= drv_reg;
      status.pin_function_sel    <= pinfn_reg;
    end
  end

  // Status snapshot toward the link; a new one only after the last was taken.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_hold_reg <= '0;
      st_req_reg  <= 1'b0;
    end else if (ce && (st_req_reg == st_ack_s2_reg)) begin
      st_hold_reg <= status;
      st_req_reg  <= ~st_req_reg;
    end
  end

endmodule : fsp_status_regs

// file: sim/fsp_chk.sv
// Purpose : Concurrent checks on the status register bank ports.
// Assumes : All checks live in the core clock domain.
// Notes   : Bound to fsp_status_regs from the bench top file.
module fsp_chk
  import fsp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire fsp_status_t status,
  input wire logic        quad_cmd_mode,
  input wire logic        guard_pin_active,
  input wire logic        pause_pin_active,
  input wire logic        reset_pin_active,
  input wire logic [6:0]  drive_pct,
  input wire logic        wsr_refused
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  fsp_status_t stat_q_reg;
  logic        rst_q_reg;
  logic        rst_q2_reg;
  logic        settled;

  function automatic logic [6:0] pct(input logic [1:0] d);
    case (d)
      2'h0:    return 7'h64;
      2'h1:    return 7'h4b;
      2'h2:    return 7'h32;
      default: return 7'h19;
    endcase
  endfunction : pct

  // Derived outputs update on the same edge as the word, and they are judged only once it held still.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_q_reg  <= 1'b1;
      rst_q2_reg <= 1'b1;
      stat_q_reg <= '0;
    end else begin
      rst_q_reg  <= 1'b0;
      rst_q2_reg <= rst_q_reg; // The lock fallback reaches the word one cycle late.
      stat_q_reg <= status;
    end
  end
  assign settled = (status == stat_q_reg) && !rst_q_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_drive_code: assert property (settled |-> drive_pct == pct(status.output_strength_sel))
    else $error("drive percent does not follow strength code");
  chk_guard_role: assert property (settled |-> guard_pin_active == !status.quad_io_enable)
    else $error("guard pin role wrong");
  chk_shared_role: assert property (settled |->
    pause_pin_active == (!status.quad_io_enable && !status.pin_function_sel) &&
    reset_pin_active == (!status.quad_io_enable && status.pin_function_sel))
    else $error("shared pin role wrong");
  chk_qpi_needs_qe: assert property ($rose(quad_cmd_mode) |-> $past(status.quad_io_enable))
    else $error("quad mode entered without quad enable");
  chk_qpi_keeps_qe: assert property (quad_cmd_mode |-> status.quad_io_enable)
    else $error("quad enable dropped in quad mode");
  chk_refused_frozen: assert property (wsr_refused |-> $stable(status) ##1 $stable(status))
    else $error("refused write changed status");
  chk_otp_sticky: assert property (($past(status.otp_region_locks) & ~status.otp_region_locks) == 3'h0)
    else $error("region lock cleared");
  chk_wel_on_done: assert property ($fell(status.busy) |-> !status.write_enable_latch)
    else $error("latch still set after operation");
  chk_rsv_zero: assert property (status.rsv_s20_s16 == 5'h00 && !status.rsv_s10)
    else $error("reserved bits not zero");
  chk_lock_hold: assert property ((!rst_q2_reg && status.sr_lock_mode[1]) |=>
    status.sr_lock_mode == $past(status.sr_lock_mode))
    else $error("lock mode left without power cycle");

  cov_refused: cover property (wsr_refused);
  cov_qpi: cover property ($rose(quad_cmd_mode));
  cov_pause: cover property ($rose(status.paused_op_flag));
  cov_done: cover property ($fell(status.busy));
endmodule : fsp_chk

// file: sim/fsp_host.sv
// Purpose : Host controller model on the link side of the register bank.
// Assumes : One command per handshake, offered only while ready is high.
// Notes   : Never reads the status back, so reserved bits never steer it.
module fsp_host
  import fsp_pkg::*;
(
  input wire logic link_clk,
  input wire logic lk_cmd_ready,
  output logic     lk_cmd_valid,
  output fsp_cmd_t lk_cmd
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Command handshake
  // ----------------------------------------------------------------
  initial begin
    lk_cmd_valid = 1'b0;
    lk_cmd       = '0;
  end

  // reserved bits ignored: the model bases no decision on read values.
  // A released bus shows the inverse so a stale word cannot pass for a command.
  task automatic send(input logic [7:0] op, input fsp_status_t d);
    int n;
    n = 0;
    @(posedge link_clk);
    while (lk_cmd_ready !== 1'b1 && n < 60) begin
      @(posedge link_clk);
      n++;
    end
    lk_cmd_valid <= 1'b1;
    lk_cmd       <= {op, d};
    @(posedge link_clk);
    lk_cmd_valid <= 1'b0;
    lk_cmd       <= ~{op, d};
    n = 0;
    while (lk_cmd_ready !== 1'b0 && n < 8) begin
      @(posedge link_clk);
      n++;
    end
  endtask : send
endmodule : fsp_host

// file: sim/tb.sv
// Purpose : Self-checking bench for the status register bank.
// Assumes : Link clock 12 ns, core clock 25 ns, unrelated phase.
// Notes   : Ordinary writes run from a row table; lock, quad and pause cases follow.
module tb
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic        wren;
    logic [7:0]  op;
    fsp_status_t data;
    fsp_status_t exp;
    logic [6:0]  pct;
  } fsp_row_t;

  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst = 1'b1;
  logic        nv_rst = 1'b1;
  logic        ce = 1'b1;
  logic        write_guard_pin = 1'b1;
  logic        op_done = 1'b0;
  logic        lk_cmd_valid;
  fsp_cmd_t    lk_cmd;
  logic        lk_cmd_ready;
  fsp_status_t lk_status;
  fsp_status_t status;
  logic        quad_cmd_mode;
  logic        guard_pin_active;
  logic        pause_pin_active;
  logic        reset_pin_active;
  logic [6:0]  drive_pct;
  logic        wsr_refused;
  int          err_total = 0;
  int          compares = 0;
  int          cycles = 0;
  int          refusals = 0;
  logic [7:0]  clr_ops [8] = '{FSP_OP_PP, FSP_OP_QPP, FSP_OP_SE, FSP_OP_BE32, FSP_OP_BE64,
                                FSP_OP_CE, FSP_OP_SECR_ER, FSP_OP_SECR_PG};
  // Each row leaves the word in the state its exp column shows.
  fsp_row_t    rows [8] = '{
    '{1'b0, FSP_OP_WREN, 24'h000000, 24'h600002, 7'h19},
    '{1'b0, FSP_OP_WRDI, 24'h000000, 24'h600000, 7'h19},
    '{1'b0, FSP_OP_WSR,  24'h000074, 24'h600000, 7'h19},
    '{1'b1, FSP_OP_WSR,  24'h004074, 24'h004074, 7'h64},
    '{1'b1, FSP_OP_WSR,  24'h204000, 24'h204000, 7'h4b},
    '{1'b1, FSP_OP_WSR,  24'h400000, 24'h400000, 7'h32},
    '{1'b1, FSP_OP_WSR,  24'he01000, 24'he01000, 7'h19},
    '{1'b1, FSP_OP_WSR,  24'h600000, 24'h601000, 7'h19}};

  // ----------------------------------------------------------------
  // Clocks, instances and helpers
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end

  fsp_status_regs dut_u (.clk(clk), .rst(rst), .nv_rst(nv_rst), .ce(ce),
    .write_guard_pin(write_guard_pin), .op_done(op_done), .link_clk(link_clk),
    .lk_cmd_valid(lk_cmd_valid), .lk_cmd(lk_cmd), .lk_cmd_ready(lk_cmd_ready),
    .lk_status(lk_status), .status(status), .quad_cmd_mode(quad_cmd_mode),
    .guard_pin_active(guard_pin_active), .pause_pin_active(pause_pin_active),
    .reset_pin_active(reset_pin_active), .drive_pct(drive_pct), .wsr_refused(wsr_refused));
  fsp_host host_u (.link_clk(link_clk), .lk_cmd_ready(lk_cmd_ready),
    .lk_cmd_valid(lk_cmd_valid), .lk_cmd(lk_cmd));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic complete_run;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Fixed wait covers the 40-cycle status write plus both crossings.
  task automatic run(input logic wren, input logic [7:0] op, input fsp_status_t d,
                     input logic pulse);
    int n;
    if (wren) host_u.send(FSP_OP_WREN, 24'h000000);
    host_u.send(op, d);
    repeat (50) @(posedge clk);
    if (pulse) begin
      op_done <= 1'b1;
      @(posedge clk);
      op_done <= 1'b0;
    end
    n = 0;
    while (pulse && status.busy !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (pulse) check(24'(status.busy), 24'h0, "busy cleared");
    repeat (20) @(posedge clk);
  endtask : run

  // A refusal pulses for one cycle, so it is counted mid-cycle where it stands.
  always @(negedge clk) begin
    if (wsr_refused === 1'b1) begin
      refusals++;
    end
  end

  // A hung handshake must still reach the verdict.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("mismatch at %0t: run timed out", $time);
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    nv_rst <= 1'b0;
    repeat (6) @(posedge clk);
    check(status, 24'h600000, "factory word");
    check(24'(pause_pin_active), 24'h1, "pause role");
    foreach (rows[i]) begin
      run(rows[i].wren, rows[i].op, rows[i].data, 1'b1);
      check(status, rows[i].exp, "row word");
      check(lk_status, rows[i].exp, "row link word");
      check(24'(drive_pct), 24'(rows[i].pct), "row drive");
    end
    $display("test rows finished");
    foreach (clr_ops[i]) begin
      run(1'b1, clr_ops[i], 24'h000000, 1'b1);
      check(status, 24'h601000, "latch after array op");
    end
    $display("test latch clear finished");
    run(1'b1, FSP_OP_WSR, 24'h601080, 1'b1);
    write_guard_pin <= 1'b0;
    run(1'b1, FSP_OP_WSR, 24'h601020, 1'b1);
    check(status, 24'h601082, "guard low write");
    write_guard_pin <= 1'b1;
    run(1'b0, FSP_OP_WSR, 24'h601020, 1'b1);
    check(status, 24'h601020, "guard high write");
    $display("test guard lock finished");
    run(1'b1, FSP_OP_WSR, 24'h601100, 1'b1);
    run(1'b1, FSP_OP_WSR, 24'h600000, 1'b1);
    check(status, 24'h601102, "power lock write");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    check(status, 24'h601000, "power cycle word");
    $display("test power lock finished");
    run(1'b0, FSP_OP_QPI_ENTER, 24'h000000, 1'b1);
    check(24'(quad_cmd_mode), 24'h0, "quad without enable");
    // pins driven: the guard pin is a live bench signal, never tied.
    run(1'b1, FSP_OP_WSR, 24'h601200, 1'b1);
    check(24'({guard_pin_active, pause_pin_active}), 24'h0, "quad pin roles");
    run(1'b0, FSP_OP_QPI_ENTER, 24'h000000, 1'b1);
    check(24'(quad_cmd_mode), 24'h1, "quad entered");
    run(1'b1, FSP_OP_WSR, 24'h601000, 1'b1);
    check(status, 24'h601200, "quad enable kept");
    run(1'b0, FSP_OP_QPI_EXIT, 24'h000000, 1'b1);
    $display("test quad finished");
    run(1'b1, FSP_OP_PP, 24'h000000, 1'b0);
    check(24'(status.busy), 24'h1, "busy during program");
    run(1'b0, FSP_OP_SUSPEND, 24'h000000, 1'b0);
    check(24'(status.paused_op_flag), 24'h1, "pause flag set");
    run(1'b0, FSP_OP_RESUME, 24'h000000, 1'b1);
    check(24'(status.paused_op_flag), 24'h0, "pause flag clear");
    check(24'(status.busy), 24'h0, "busy after done");
    $display("test suspend finished");
    ce <= 1'b0;
    host_u.send(FSP_OP_WREN, 24'h000000);
    repeat (20) @(posedge clk);
    check(status, 24'h601200, "frozen by enable");
    ce <= 1'b1;
    repeat (20) @(posedge clk);
    check(status, 24'h601202, "latch after enable");
    check(24'(refusals), 24'h3, "refused count");
    $display("test clock enable finished");
    complete_run();
  end
endmodule : tb

bind fsp_status_regs fsp_chk chk_u (.clk(clk), .rst(rst), .status(status),
  .quad_cmd_mode(quad_cmd_mode), .guard_pin_active(guard_pin_active),
  .pause_pin_active(pause_pin_active), .reset_pin_active(reset_pin_active),
  .drive_pct(drive_pct), .wsr_refused(wsr_refused));
